// *** rtl/pwm_gen_fault_and_enable.sv ***
// Four-generator PWM run gating, fault triggers and interrupt status behind APB.
`timescale 1ns/1ps
module pwm_gen_fault_and_enable #(
  parameter int NG = pwm_fault_pkg::NUM_GEN
) (
  input  wire logic                           clk,
  input  wire logic                           reset_n,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [11:0]                    paddr,
  input  wire logic [31:0]                    pwdata,
  output logic [31:0]                         prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic [pwm_fault_pkg::NUM_FAULT-1:0] faultInputPin,
  input  wire logic [NG*pwm_fault_pkg::NUM_EVENT-1:0] genEvent,
  output logic [NG-1:0]                       genFault,
  output logic [NG*pwm_fault_pkg::COUNT_W-1:0] genCount,
  output logic                                irq
);

  localparam int NF = pwm_fault_pkg::NUM_FAULT;
  localparam int NE = pwm_fault_pkg::NUM_EVENT;
  localparam int CW = pwm_fault_pkg::COUNT_W;
  localparam int PW = pwm_fault_pkg::PERIOD_W;

  // Elaboration checks refuse settings that the decode or the data word cannot serve.
  if (NG != pwm_fault_pkg::NUM_GEN) begin : bad_gen_count
    $error("generator count must match the register map");
  end
  if (NF > 32 || NE > 32 || CW > 32 || PW > 32) begin : bad_field_width
    $error("a register field is wider than the data word");
  end
  if (pwm_fault_pkg::GEN_STRIDE <= 12'(pwm_fault_pkg::OFS_COUNT)) begin : bad_stride
    $error("generator window too small for its registers");
  end
  if (pwm_fault_pkg::ADDR_GIRQ_MASK >= pwm_fault_pkg::GEN_BASE) begin : bad_base
    $error("global registers overlap the generator windows");
  end
  if (int'(pwm_fault_pkg::GEN_BASE) + NG * int'(pwm_fault_pkg::GEN_STRIDE)
      > 4096) begin : bad_span
    $error("generator windows run past the address space");
  end

  // Register map, one 32-bit word per register, unused upper bits read as zero.
  //   Global registers:
  //     ENABLE     run bit per generator; a clear bit freezes that counter.
  //     GIRQ_STAT  live fault interrupt per generator, read only.
  //     GIRQ_MASK  reserved; reads zero and ignores writes.
  //   Per-generator window at GEN_BASE plus GEN_STRIDE times the generator number:
  //     MODE      bit 0 latched triggers, bit 1 minimum period, bit 2 extended sources.
  //     SENSE     one bit per fault input; a one makes that input active low.
  //     MINPER    minimum fault period in clock cycles.
  //     TRIGSEL   source mask for extended-source mode, one bit per fault input.
  //     FSTAT     fault trigger status; writing ones clears latched triggers.
  //     IRQ_STAT  sticky counter event bits, cleared by writing ones.
  //     IRQ_MASK  per-event enable of the interrupt output.
  //     COUNT     the generator's counter, read only.
  // Any other address, and any address whose two low bits are not zero, is answered
  // with pslverr, read data of zero and no side effect.
  //
  // Bus timing: the access is taken on the edge that closes its first access cycle,
  // and pready and pslverr stand for exactly the next cycle; prdata holds until the next access. A write takes
  // effect on the taking edge, so a read that follows back to back sees it. The
  // idle-and-respond pair keeps the held request from being taken twice while the
  // master waits to see pready.
  //
  // Interrupt output: any unmasked event bit or any generator fault. The fault part
  // is not maskable so a stretched fault keeps the line up for its whole duration;
  // a handler that returns before the stretch expires will be entered again.
  //
  // Fault path: each pin is first sense-adjusted per generator, then masked by the
  // source selection (input 0 alone unless extended sources are on) and ORed. The
  // unit registers the result and this module registers it once more, so a pin
  // change shows on genFault two cycles after the unit sees it. The extra stage
  // keeps every top-level output straight from a flip-flop at the cost of latency.
  //
  // Hazards: a counter event that arrives with its own write-one clear is kept, so
  // software never loses an event. Latched triggers collect in every mode and only
  // show in the status when latched mode is on; clear them before turning it on.
  // A disabled generator holds its count rather than clearing it, so re-enabling
  // resumes from where it stopped.

  typedef enum logic [1:0] {IDLE, RESP} bus_state_type;

  typedef struct packed {
    bus_state_type                          bus;
    logic [NG-1:0]                          enable;
    pwm_fault_pkg::gen_cfg_type [NG-1:0]    cfg;
    logic [NG-1:0][NE-1:0]                  irqStat;
    logic [NG-1:0][NE-1:0]                  irqMask;
    logic [NG-1:0][CW-1:0]                  count;
    logic [NG-1:0]                          faultIrq;
    logic [NG-1:0]                          faultOutQ;
    logic [31:0]                            rdata;
    logic                                   ready;
    logic                                   slverr;
    logic                                   irq;
  } state_type;

  state_type state_q;
  state_type state_d;

  logic [NG-1:0][NF-1:0] faultStatus;
  logic [NG-1:0][NF-1:0] clearLatched;
  logic [NG-1:0]         faultRaw;

  // Decodes an address into a generator index; returns NG for none.
  function automatic int genIndex(input logic [11:0] a);
    int k;
    k = NG;
    for (int g = 0; g < NG; g++) begin
      if (a >= pwm_fault_pkg::GEN_BASE + 12'(g) * pwm_fault_pkg::GEN_STRIDE
          && a < pwm_fault_pkg::GEN_BASE + 12'(g + 1) * pwm_fault_pkg::GEN_STRIDE) begin
        k = g;
      end
    end
    return k;
  endfunction

  // Offset within a generator window.
  function automatic logic [5:0] genOffset(input logic [11:0] a);
    return a[5:0];
  endfunction

  // One fault unit per generator.
  for (genvar g = 0; g < NG; g++) begin : gen_unit
    pwm_fault_unit #(
      .NF (NF),
      .PW (PW)
    ) unit (
      .clk           (clk),
      .reset_n       (reset_n),
      .faultInputPin (faultInputPin),
      .cfg           (state_q.cfg[g]),
      .clearLatched  (clearLatched[g]),
      .faultStatus   (faultStatus[g]),
      .faultOut      (faultRaw[g])
    );
  end

  // Bus access, counters, event capture and interrupt combine.
  always_comb begin
    int gi;
    logic [5:0] ofs;
    logic access;
    logic hit;
    logic [NG*NE-1:0] pend;
    gi = genIndex(paddr);
    ofs = genOffset(paddr);
    access = psel && penable && state_q.bus == IDLE;
    hit = 1'b0;
    pend = '0;
    state_d = state_q;
    clearLatched = '0;
    state_d.ready = 1'b0;
    state_d.slverr = 1'b0;

    // Each counter advances only while its generator runs.
    for (int g = 0; g < NG; g++) begin
      if (state_q.enable[g]) begin
        state_d.count[g] = state_q.count[g] + CW'(1); // [R01]
      end else begin
        state_d.count[g] = state_q.count[g]; // [R02]
      end
      state_d.faultOutQ[g] = faultRaw[g];
      // The fault interrupt follows the stretched fault, not the raw pin.
      state_d.faultIrq[g] = faultRaw[g]; // [R15]
    end

    // A single wait state gives a registered read path; pready rises one cycle later.
    unique case (state_q.bus)
      IDLE: begin
        if (access) begin
          state_d.bus = RESP;
          state_d.rdata = '0;
          if (paddr == pwm_fault_pkg::ADDR_ENABLE) begin
            hit = 1'b1;
            if (pwrite) begin
              state_d.enable = pwdata[NG-1:0]; // [R01] [R02]
            end
            state_d.rdata[NG-1:0] = state_q.enable;
          end else if (paddr == pwm_fault_pkg::ADDR_GIRQ_STAT) begin
            hit = 1'b1;
            state_d.rdata[NG-1:0] = state_q.faultIrq;
          end else if (paddr == pwm_fault_pkg::ADDR_GIRQ_MASK) begin
            hit = 1'b1;
          end else if (gi < NG && paddr[1:0] == 2'b00) begin
            hit = 1'b1;
            unique case (ofs)
              pwm_fault_pkg::OFS_MODE: begin
                if (pwrite) begin
                  state_d.cfg[gi].latchedTriggerMode =
                    pwdata[pwm_fault_pkg::MODE_LATCH]; // [R14]
                  state_d.cfg[gi].minFaultPeriodMode = pwdata[pwm_fault_pkg::MODE_MINPER];
                  state_d.cfg[gi].extendedFaultSourceMode =
                    pwdata[pwm_fault_pkg::MODE_EXTSRC];
                end
                state_d.rdata[pwm_fault_pkg::MODE_LATCH] = state_q.cfg[gi].latchedTriggerMode;
                state_d.rdata[pwm_fault_pkg::MODE_MINPER] = state_q.cfg[gi].minFaultPeriodMode;
                state_d.rdata[pwm_fault_pkg::MODE_EXTSRC] =
                  state_q.cfg[gi].extendedFaultSourceMode;
              end
              pwm_fault_pkg::OFS_SENSE: begin
                if (pwrite) begin
                  state_d.cfg[gi].faultSenseActiveLow = pwdata[NF-1:0]; // [R03]
                end
                state_d.rdata[NF-1:0] = state_q.cfg[gi].faultSenseActiveLow;
              end
              pwm_fault_pkg::OFS_MINPER: begin
                if (pwrite) begin
                  state_d.cfg[gi].minPeriod = pwdata[PW-1:0]; // [R04]
                end
                state_d.rdata[PW-1:0] = state_q.cfg[gi].minPeriod;
              end
              pwm_fault_pkg::OFS_TRIGSEL: begin
                if (pwrite) begin
                  state_d.cfg[gi].trigSel = pwdata[NF-1:0]; // [R08]
                end
                state_d.rdata[NF-1:0] = state_q.cfg[gi].trigSel; // [R09]
              end
              pwm_fault_pkg::OFS_FSTAT: begin
                if (pwrite) begin
                  clearLatched[gi] = pwdata[NF-1:0]; // [R12] [R16]
                end
                state_d.rdata[NF-1:0] = faultStatus[gi]; // [R10] [R11]
              end
              pwm_fault_pkg::OFS_IRQ_STAT: begin
                state_d.rdata[NE-1:0] = state_q.irqStat[gi];
              end
              pwm_fault_pkg::OFS_IRQ_MASK: begin
                if (pwrite) begin
                  state_d.irqMask[gi] = pwdata[NE-1:0];
                end
                state_d.rdata[NE-1:0] = state_q.irqMask[gi];
              end
              pwm_fault_pkg::OFS_COUNT: begin
                state_d.rdata[CW-1:0] = state_q.count[gi];
              end
              default: begin
                hit = 1'b0;
              end
            endcase
          end
          if (!hit) begin
            state_d.rdata = '0;
          end
          state_d.ready = 1'b1;
          state_d.slverr = !hit;
        end
      end
      RESP: begin
        state_d.bus = IDLE;
      end
      default: begin
        state_d.bus = IDLE;
      end
    endcase

    // Events set sticky bits; a set in the same cycle as its clear wins.
    for (int g = 0; g < NG; g++) begin
      logic [NE-1:0] clr;
      clr = '0;
      if (access && pwrite && gi == g && ofs == pwm_fault_pkg::OFS_IRQ_STAT) begin
        clr = pwdata[NE-1:0]; // [R13]
      end
      state_d.irqStat[g] = (state_q.irqStat[g] & ~clr) | genEvent[g*NE +: NE]; // [R13]
      pend[g*NE +: NE] = state_q.irqStat[g] & state_q.irqMask[g];
    end
    state_d.irq = |pend || |state_q.faultIrq;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '0;
      for (int g = 0; g < NG; g++) begin
        state_q.cfg[g].trigSel <= pwm_fault_pkg::TRIGSEL_RESET; // [R07]
        state_q.cfg[g].faultSenseActiveLow <= pwm_fault_pkg::SENSE_RESET;
      end
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flip-flops.
  assign prdata = state_q.rdata;
  assign pready = state_q.ready;
  assign pslverr = state_q.slverr;
  assign genFault = state_q.faultOutQ;
  assign genCount = state_q.count;
  assign irq = state_q.irq;

endmodule

// *** rtl/pwm_fault_pkg.sv ***
// Constants, register map and carrier types for the PWM fault and enable block.
//
// Contract
// [R01] An enabled generator's counter advances on every PWM clock.
// [R02] A disabled generator's counter holds its value.
// [R03] Each generator holds an active-high or active-low sense per fault input, applied first.
// [R04] Each generator holds a minimum fault period in clocks, used only in that mode.
// [R05] In minimum-period mode a fault stays asserted at least the programmed clock count.
// [R06] The generator fault is the OR of its selected, sense-adjusted inputs.
// [R07] After reset and outside extended-source mode only fault input 0 is a source.
// [R08] In extended-source mode the programmable trigger mask selects the sources.
// [R09] The trigger mask, one bit per fault input of group 0, reads back.
// [R10] Fault status shows live triggers, or latched triggers in latched mode.
// [R11] A status bit at one means the trigger is active, at zero inactive.
// [R12] In latched mode a latched trigger bit stays set until software clears it.
// [R13] Generator interrupt status bits for six counter events clear on a written one.
// [R14] Each generator selects latched or unlatched fault behaviour.
// [R15] The fault interrupt stays asserted for the whole stretched fault.
// [R16] Latched trigger bits clear where a one is written; zeros leave them alone.
package pwm_fault_pkg;

  localparam int NUM_GEN    = 4;
  localparam int NUM_FAULT  = 4;
  localparam int PERIOD_W   = 16;
  localparam int COUNT_W    = 16;
  localparam int NUM_EVENT  = 6;

  // Word addresses of the global registers.
  localparam logic [11:0] ADDR_ENABLE    = 12'h000;
  localparam logic [11:0] ADDR_GIRQ_STAT = 12'h004;
  localparam logic [11:0] ADDR_GIRQ_MASK = 12'h008;
  // Per-generator register window.
  localparam logic [11:0] GEN_BASE       = 12'h040;
  localparam logic [11:0] GEN_STRIDE     = 12'h040;
  localparam logic [5:0]  OFS_MODE       = 6'h00;
  localparam logic [5:0]  OFS_SENSE      = 6'h04;
  localparam logic [5:0]  OFS_MINPER     = 6'h08;
  localparam logic [5:0]  OFS_TRIGSEL    = 6'h0c;
  localparam logic [5:0]  OFS_FSTAT      = 6'h10;
  localparam logic [5:0]  OFS_IRQ_STAT   = 6'h14;
  localparam logic [5:0]  OFS_IRQ_MASK   = 6'h18;
  localparam logic [5:0]  OFS_COUNT      = 6'h1c;

  // Mode register bit positions.
  localparam int MODE_LATCH  = 0;
  localparam int MODE_MINPER = 1;
  localparam int MODE_EXTSRC = 2;

  // Event bit positions in the generator interrupt status.
  localparam int EV_CNT_ZERO = 0;
  localparam int EV_CNT_LOAD = 1;
  localparam int EV_CMP_AU   = 2;
  localparam int EV_CMP_AD   = 3;
  localparam int EV_CMP_BU   = 4;
  localparam int EV_CMP_BD   = 5;

  // Reset values.
  localparam logic [NUM_FAULT-1:0] TRIGSEL_RESET = 4'h1;
  localparam logic [NUM_FAULT-1:0] SENSE_RESET   = 4'h0;

  // Per-generator fault configuration.
  typedef struct packed {
    logic                 latchedTriggerMode;
    logic                 minFaultPeriodMode;
    logic                 extendedFaultSourceMode;
    logic [NUM_FAULT-1:0] faultSenseActiveLow;
    logic [NUM_FAULT-1:0] trigSel;
    logic [PERIOD_W-1:0]  minPeriod;
  } gen_cfg_type;

  // Per-generator fault state.
  typedef struct packed {
    logic [NUM_FAULT-1:0] latched;
    logic [PERIOD_W-1:0]  stretch;
    logic                 fault;
  } gen_fault_type;

  // APB request bundle.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

endpackage

// *** rtl/pwm_fault_unit.sv ***
// One generator's fault sense, selection, stretching and latching.
`timescale 1ns/1ps
module pwm_fault_unit #(
  parameter int NF = pwm_fault_pkg::NUM_FAULT,
  parameter int PW = pwm_fault_pkg::PERIOD_W
) (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic [NF-1:0]              faultInputPin,
  input  wire pwm_fault_pkg::gen_cfg_type cfg,
  input  wire logic [NF-1:0]              clearLatched,
  output logic [NF-1:0]                   faultStatus,
  output logic                            faultOut
);

  // Elaboration check: the configuration struct fixes both widths.
  if (NF != pwm_fault_pkg::NUM_FAULT || PW != pwm_fault_pkg::PERIOD_W) begin : bad_width
    $error("pwm_fault_unit widths must match the package");
  end

  pwm_fault_pkg::gen_fault_type state_q;
  pwm_fault_pkg::gen_fault_type state_d;
  logic [NF-1:0] trig;
  logic [NF-1:0] srcSel;
  logic          rawFault;

  // Sense, select, combine, stretch and latch.
  always_comb begin
    state_d = state_q;
    trig = faultInputPin ^ cfg.faultSenseActiveLow; // [R03]
    srcSel = cfg.extendedFaultSourceMode ? cfg.trigSel : NF'(1); // [R07] [R08]
    rawFault = |(trig & srcSel); // [R06]
    // Set wins over clear so a trigger arriving with its clear is kept.
    state_d.latched = (state_q.latched & ~clearLatched) | (trig & srcSel); // [R12] [R16]
    if (rawFault) begin
      state_d.stretch = cfg.minPeriod; // [R04]
    end else if (state_q.stretch != '0) begin
      state_d.stretch = state_q.stretch - PW'(1);
    end
    // Stretch counts in every mode but only holds the fault when the mode is on; the window is the minimum period.
    state_d.fault = rawFault
      || (cfg.minFaultPeriodMode && state_q.stretch > PW'(1)); // [R05] [R15]
    faultStatus = cfg.latchedTriggerMode ? state_q.latched : (trig & srcSel); // [R10] [R11] [R14]
    faultOut = state_q.fault;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

endmodule

// *** test/fault_pin_model.sv ***
// Behavioural source for the four external fault pins.
`timescale 1ns/1ps
module fault_pin_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [3:0] pinReq,
  output logic      [3:0] faultInputPin
);
  // Pins move just after an edge, like a synchronous source, so sampling never races.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      faultInputPin <= 4'h0;
    end else begin
      faultInputPin <= pinReq;
    end
  end
endmodule

// *** test/pwm_fault_chk.sv ***
// Concurrent checks on the ports of the PWM fault and enable block.
`timescale 1ns/1ps
module pwm_fault_chk #(
  parameter int NG = 4
) (
  input wire logic                                     clk,
  input wire logic                                     reset_n,
  input wire logic                                     psel,
  input wire logic                                     penable,
  input wire logic                                     pwrite,
  input wire logic [11:0]                              paddr,
  input wire logic [31:0]                              pwdata,
  input wire logic [31:0]                              prdata,
  input wire logic                                     pready,
  input wire logic                                     pslverr,
  input wire logic [pwm_fault_pkg::NUM_FAULT-1:0]      faultInputPin,
  input wire logic [NG*pwm_fault_pkg::NUM_EVENT-1:0]   genEvent,
  input wire logic [NG-1:0]                            genFault,
  input wire logic [NG*pwm_fault_pkg::COUNT_W-1:0]     genCount,
  input wire logic                                     irq
);
  logic [NG-1:0] enShadow;
  // Shadow of the enable word, caught on the edge where the slave accepts the write.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enShadow <= '0;
    end else if (psel && penable && pwrite && !pready && paddr == 12'h000) begin
      enShadow <= pwdata[NG-1:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ready_after_take_a: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered on the next cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("ready without an access");
  err_with_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  unaligned_err_a: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("unaligned access accepted");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  fault_irq_a: assert property (|genFault |-> ##[0:1] irq)
    else $error("fault without interrupt");
  for (genvar g = 0; g < NG; g++) begin : gen_cnt
    count_step_a: assert property (
      genCount[g*16 +: 16] ==
        16'($past(genCount[g*16 +: 16]) + $past(enShadow[g])))
      else $error("counter step differs from enable");
  end
endmodule

bind pwm_gen_fault_and_enable pwm_fault_chk #(.NG(NG)) i_pwm_fault_chk (.clk, .reset_n,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .faultInputPin,
  .genEvent, .genFault, .genCount, .irq);

// *** test/tb.sv ***
// Self-checking bench for the PWM fault and enable block over APB.
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  faultInputPin;
  logic [3:0]  pinReq = 4'h0;
  logic [23:0] genEvent = 24'h0;
  logic [3:0]  genFault;
  logic [63:0] genCount;
  logic        irq;
  logic [63:0] c0;
  logic [31:0] rd;
  logic        e;
  logic        i1;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cycles = 0;
  localparam logic [5:0] MD = pwm_fault_pkg::OFS_MODE;
  localparam logic [5:0] FS = pwm_fault_pkg::OFS_FSTAT;
  localparam logic [5:0] TS = pwm_fault_pkg::OFS_TRIGSEL;
  localparam logic [5:0] IS = pwm_fault_pkg::OFS_IRQ_STAT;

  pwm_gen_fault_and_enable i_pwm_gen_fault_and_enable (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .faultInputPin(faultInputPin),
    .genEvent(genEvent), .genFault(genFault), .genCount(genCount), .irq(irq));
  fault_pin_model i_fault_pin_model (.clk(clk), .reset_n(reset_n), .pinReq(pinReq),
    .faultInputPin(faultInputPin));

  // 10 MHz clock.
  always #50 clk = ~clk;

  // A hang costs a mismatch; the run is a few hundred cycles at most.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One APB transfer; the request stands until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_mismatch++;
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [11:0] ga(input int g, input logic [5:0] o);
    return pwm_fault_pkg::GEN_BASE + pwm_fault_pkg::GEN_STRIDE * 12'(g) + {6'h00, o};
  endfunction

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Main sequence: defaults, sources, sense, stretch, latch, gating, events.
  initial begin
    cyc(4);
    reset_n <= 1'b1;
    rchk(ga(0, TS), 32'h1);
    rchk(ga(3, pwm_fault_pkg::OFS_SENSE), 32'h0);
    rchk(ga(0, MD), 32'h0);
    apb(1'b0, 12'h3fc, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 12'h042, 32'h0);
    chk({31'h0, e}, 32'h1);
    pinReq <= 4'h2;
    cyc(5);
    chk({28'h0, genFault}, 32'h0);
    pinReq <= 4'h1;
    cyc(5);
    chk({28'h0, genFault}, 32'hf);
    rchk(ga(0, FS), 32'h1);
    pinReq <= 4'h0;
    cyc(5);
    chk({28'h0, genFault}, 32'h0);
    rchk(ga(0, FS), 32'h0);
    apb(1'b1, ga(2, pwm_fault_pkg::OFS_SENSE), 32'h1);
    cyc(5);
    chk({28'h0, genFault}, 32'h4);
    pinReq <= 4'h1;
    cyc(5);
    chk({28'h0, genFault}, 32'hb);
    pinReq <= 4'h0;
    apb(1'b1, ga(2, pwm_fault_pkg::OFS_SENSE), 32'h0);
    apb(1'b1, ga(3, MD), 32'h4);
    apb(1'b1, ga(3, TS), 32'h4);
    rchk(ga(3, TS), 32'h4);
    pinReq <= 4'h1;
    cyc(5);
    chk({28'h0, genFault}, 32'h7);
    pinReq <= 4'h4;
    cyc(5);
    chk({28'h0, genFault}, 32'h8);
    pinReq <= 4'h0;
    apb(1'b1, ga(1, pwm_fault_pkg::OFS_MINPER), 32'h14);
    apb(1'b1, ga(1, MD), 32'h2);
    pinReq <= 4'h1;
    cyc(1);
    pinReq <= 4'h0;
    cyc(12);
    chk({28'h0, genFault}, 32'h2);
    chk({31'h0, irq}, 32'h1);
    cyc(30);
    chk({28'h0, genFault}, 32'h0);
    apb(1'b1, ga(3, MD), 32'h5);
    apb(1'b1, ga(3, TS), 32'h5);
    apb(1'b1, ga(3, FS), 32'hf);
    pinReq <= 4'h5;
    cyc(3);
    pinReq <= 4'h0;
    cyc(5);
    rchk(ga(3, FS), 32'h5);
    apb(1'b1, ga(3, FS), 32'h1);
    rchk(ga(3, FS), 32'h4);
    apb(1'b1, ga(3, FS), 32'h4);
    rchk(ga(3, FS), 32'h0);
    apb(1'b1, pwm_fault_pkg::ADDR_ENABLE, 32'h2);
    c0 = genCount;
    cyc(10);
    chk({16'h0, genCount[31:16]}, {16'h0, c0[31:16] + 16'h000a});
    chk({16'h0, genCount[15:0]}, 32'h0);
    apb(1'b1, pwm_fault_pkg::ADDR_ENABLE, 32'h0);
    c0 = genCount;
    cyc(10);
    chk(genCount[63:32], c0[63:32]);
    rchk(ga(1, pwm_fault_pkg::OFS_COUNT), {16'h0, c0[31:16]});
    for (int k = 0; k < 6; k++) begin
      genEvent <= 24'h1 << k;
      cyc(1);
    end
    genEvent <= 24'h0;
    rchk(ga(0, IS), 32'h3f);
    apb(1'b1, ga(0, IS), 32'h5);
    rchk(ga(0, IS), 32'h3a);
    apb(1'b1, ga(0, pwm_fault_pkg::OFS_IRQ_MASK), 32'h3f);
    cyc(3);
    i1 = irq;
    apb(1'b1, ga(0, pwm_fault_pkg::OFS_IRQ_MASK), 32'h0);
    cyc(3);
    chk({31'h0, i1 ^ irq}, 32'h1);
    apb(1'b1, ga(0, IS), 32'h3a);
    apb(1'b1, ga(0, pwm_fault_pkg::OFS_IRQ_MASK), 32'h3f);
    cyc(3);
    chk({31'h0, irq}, 32'h0);
    report_and_stop();
  end
endmodule
